// ===== include/pin_mux_defs.vh
// register offsets, reset values and encodings for the pin function select block
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CLOCK_OPTION 8'h00
`define OFS_PORT_A_DATA 8'h04
`define OFS_PORT_A_DIR 8'h08
`define OFS_PORT_A_PULLUP 8'h0C
`define OFS_KEYBOARD_ENABLE 8'h10
`define OFS_TIMER_PIN_ENABLE 8'h14
`define OFS_PORT_B_DATA 8'h18
`define OFS_PORT_B_DIR 8'h1C
`define OFS_PIN_LEVEL 8'h20
`define OFS_PIN_STATE 8'h24

// ----------------------------------------------------------------
// clock option encodings
// ----------------------------------------------------------------
`define CLKOPT_INTERNAL 2'h0
`define CLKOPT_EXTERNAL 2'h1
`define CLKOPT_CRYSTAL 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CLOCK_OPTION 2'h0
`define RST_PORT_A 5'h00
`define RST_PORT_B 8'h00

// ----------------------------------------------------------------
// field positions in the read-only registers
// ----------------------------------------------------------------
`define LVL_PORT_B_LSB 8
`define LVL_EXT_IRQ_BIT 16
`define ST_OSC_IN_BIT 8
`define ST_OSC_OUT_BIT 9

// ----------------------------------------------------------------
// port widths and pin positions
// ----------------------------------------------------------------
`define PORT_A_WIDTH 5
`define PORT_B_WIDTH 8
`define PB_OSC_OUT 7
`define PB_OSC_IN 6
`define PB_SERIAL_RX 5
`define PB_SERIAL_TX 4
`define ADC_PINS 4

`endif

// ===== hw/pin_sync2.v
// two-flop synchroniser bank for pins arriving from outside the clock domain
module pin_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // pins and synchronised levels
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level
);

  // the first stage is read by the second stage only
  reg [WIDTH-1:0] stage1;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      stage1 <= pin_in;
      level <= stage1;
    end
  end

endmodule

// ===== hw/port_a_pin_mux.v
// per-pin function and pullup selection for one port A pin
module port_a_pin_mux (
  // software settings
  input wire gpio_data,
  input wire gpio_dir,
  input wire pullup_ctrl,
  input wire keyboard_enable,
  input wire timer_enable,
  // timer channel unit drive
  input wire timer_out,
  input wire timer_oe,
  // next pad values
  output reg next_out,
  output reg next_oe,
  output reg next_pullup
);

  always @* begin
    next_out = gpio_data;
    next_oe = gpio_dir;
    next_pullup = 1'b0;
    if (timer_enable) begin
      // timer owns the pin and its pullup is forced off
      next_out = timer_out;
      next_oe = timer_oe;
      next_pullup = 1'b0;
    end else if (keyboard_enable) begin
      // a keyboard input never drives; its pullup is always on
      next_out = 1'b0;
      next_oe = 1'b0;
      next_pullup = 1'b1;
    end else begin
      // output pins keep the software pullup off
      next_pullup = pullup_ctrl & ~gpio_dir;
    end
  end

endmodule

// ===== hw/port_pin_function_select.v
// pin function select and pullup control with an AHB-Lite register slave
// How it works
// - oscillator pins connect only for external/crystal options
// - crystal option withdraws port B bits 7, 6
// - external clock withdraws only port B bit 6
// - each port A pin independently selectable keyboard input
// - keyboard-enabled pin has pullup on unless the timer function also owns that pin
// - per-pin software pullup on general inputs
// - timer function forces that pin's pullup off
// - external interrupt pin asynchronous, permanent pullup
// - port B 5,4 serial; 3..0 analog inputs
`include "pin_mux_defs.vh"

module port_pin_function_select (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // port A pads
  input wire [4:0] port_a_pin_in,
  output reg [4:0] port_a_pin_out,
  output reg [4:0] port_a_pin_oe,
  output reg [4:0] port_a_pin_pullup,
  // port B pads
  input wire [7:0] port_b_pin_in,
  output reg [7:0] port_b_pin_out,
  output reg [7:0] port_b_pin_oe,
  // oscillator pin connection
  output reg oscillator_input_pin_enable,
  output reg oscillator_output_pin_enable,
  // external interrupt pin
  input wire external_interrupt_pin,
  output reg external_interrupt_pullup,
  output reg external_interrupt_level,
  // keyboard interrupt unit
  output reg [4:0] keyboard_interrupt_input,
  // timer channel unit
  input wire [4:0] timer_out,
  input wire [4:0] timer_oe,
  output reg [4:0] timer_capture_input,
  // serial comm interface
  input wire serial_enable,
  input wire serial_txd,
  output reg serial_rxd,
  // analog-to-digital converter
  input wire [3:0] adc_channel_enable,
  output reg [3:0] adc_pin_connect
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [1:0] clock_option;
  reg [4:0] port_a_data;
  reg [4:0] port_a_dir;
  reg [4:0] port_a_pullup_ctrl;
  reg [4:0] keyboard_enable;
  reg [4:0] timer_pin_enable;
  reg [7:0] port_b_data;
  reg [7:0] port_b_dir;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  reg [7:0] addr_q;
  reg write_pending;
  reg read_wait;
  wire access = hsel & hready & htrans[1];
  reg [31:0] read_mux;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] port_a_level;
  wire [7:0] port_b_level;
  wire ext_irq_level;

  pin_sync2 #(
    .WIDTH(`PORT_A_WIDTH),
    .RESET_VALUE(5'h1F)
  ) sync_port_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(port_a_pin_in),
    .level(port_a_level)
  );

  pin_sync2 #(
    .WIDTH(`PORT_B_WIDTH),
    .RESET_VALUE(8'hFF)
  ) sync_port_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(port_b_pin_in),
    .level(port_b_level)
  );

  // idle level is high, matching the pulled-up pin
  pin_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) sync_ext_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(external_interrupt_pin),
    .level(ext_irq_level)
  );

  // ----------------------------------------------------------------
  // port A per-pin selection
  // ----------------------------------------------------------------
  wire [4:0] next_a_out;
  wire [4:0] next_a_oe;
  wire [4:0] next_a_pullup;

  genvar gi;
  generate
    for (gi = 0; gi < `PORT_A_WIDTH; gi = gi + 1) begin : g_port_a
      port_a_pin_mux pin_mux (
        .gpio_data(port_a_data[gi]),
        .gpio_dir(port_a_dir[gi]),
        .pullup_ctrl(port_a_pullup_ctrl[gi]),
        .keyboard_enable(keyboard_enable[gi]),
        .timer_enable(timer_pin_enable[gi]),
        .timer_out(timer_out[gi]),
        .timer_oe(timer_oe[gi]),
        .next_out(next_a_out[gi]),
        .next_oe(next_a_oe[gi]),
        .next_pullup(next_a_pullup[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // port B and oscillator selection
  // ----------------------------------------------------------------
  reg [7:0] next_b_out;
  reg [7:0] next_b_oe;
  reg next_osc_in;
  reg next_osc_out;

  always @* begin
    next_b_out = port_b_data;
    next_b_oe = port_b_dir;
    // oscillator pins exist only for the two off-chip clock options
    next_osc_in = (clock_option == `CLKOPT_EXTERNAL) ||
      (clock_option == `CLKOPT_CRYSTAL);
    next_osc_out = (clock_option == `CLKOPT_CRYSTAL);
    if (next_osc_in) begin
      next_b_out[`PB_OSC_IN] = 1'b0;
      next_b_oe[`PB_OSC_IN] = 1'b0;
    end
    if (next_osc_out) begin
      next_b_out[`PB_OSC_OUT] = 1'b0;
      next_b_oe[`PB_OSC_OUT] = 1'b0;
    end
    if (serial_enable) begin
      next_b_out[`PB_SERIAL_TX] = serial_txd;
      next_b_oe[`PB_SERIAL_TX] = 1'b1;
      next_b_out[`PB_SERIAL_RX] = 1'b0;
      next_b_oe[`PB_SERIAL_RX] = 1'b0;
    end
    // an analog channel turns the digital driver off
    next_b_out[3:0] = port_b_data[3:0] & ~adc_channel_enable;
    next_b_oe[3:0] = port_b_dir[3:0] & ~adc_channel_enable;
  end

  // ----------------------------------------------------------------
  // pad and peripheral outputs
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pin_out <= 5'h00;
      port_a_pin_oe <= 5'h00;
      port_a_pin_pullup <= 5'h00;
      port_b_pin_out <= 8'h00;
      port_b_pin_oe <= 8'h00;
      oscillator_input_pin_enable <= 1'b0;
      oscillator_output_pin_enable <= 1'b0;
      external_interrupt_pullup <= 1'b1;
      external_interrupt_level <= 1'b1;
      keyboard_interrupt_input <= 5'h1F;
      timer_capture_input <= 5'h1F;
      serial_rxd <= 1'b1;
      adc_pin_connect <= 4'h0;
    end else begin
      port_a_pin_out <= next_a_out;
      port_a_pin_oe <= next_a_oe;
      port_a_pin_pullup <= next_a_pullup;
      port_b_pin_out <= next_b_out;
      port_b_pin_oe <= next_b_oe;
      oscillator_input_pin_enable <= next_osc_in;
      oscillator_output_pin_enable <= next_osc_out;
      // pullup on the interrupt pin is never released
      external_interrupt_pullup <= 1'b1;
      external_interrupt_level <= ext_irq_level;
      // disabled keyboard pins show the inactive high level
      keyboard_interrupt_input <= port_a_level | ~keyboard_enable;
      timer_capture_input <= port_a_level | ~timer_pin_enable;
      serial_rxd <= serial_enable ? port_b_level[`PB_SERIAL_RX] : 1'b1;
      adc_pin_connect <= adc_channel_enable;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @* begin
    read_mux = 32'h00000000;
    case (addr_q)
      `OFS_CLOCK_OPTION: read_mux[1:0] = clock_option;
      `OFS_PORT_A_DATA: read_mux[4:0] = port_a_data;
      `OFS_PORT_A_DIR: read_mux[4:0] = port_a_dir;
      `OFS_PORT_A_PULLUP: read_mux[4:0] = port_a_pullup_ctrl;
      `OFS_KEYBOARD_ENABLE: read_mux[4:0] = keyboard_enable;
      `OFS_TIMER_PIN_ENABLE: read_mux[4:0] = timer_pin_enable;
      `OFS_PORT_B_DATA: read_mux[7:0] = port_b_data;
      `OFS_PORT_B_DIR: read_mux[7:0] = port_b_dir;
      `OFS_PIN_LEVEL: begin
        read_mux[4:0] = port_a_level;
        read_mux[`LVL_PORT_B_LSB +: 8] = port_b_level;
        read_mux[`LVL_EXT_IRQ_BIT] = ext_irq_level;
      end
      `OFS_PIN_STATE: begin
        read_mux[4:0] = port_a_pin_pullup;
        read_mux[`ST_OSC_IN_BIT] = oscillator_input_pin_enable;
        read_mux[`ST_OSC_OUT_BIT] = oscillator_output_pin_enable;
      end
      default: read_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes with no wait, reads with one wait state
  // ----------------------------------------------------------------
  // the read wait state lets a write in the previous data phase land
  // before the read mux is sampled, so no forwarding path is needed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      write_pending <= 1'b0;
      read_wait <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (read_wait) begin
        hrdata <= read_mux;
        hreadyout <= 1'b1;
        read_wait <= 1'b0;
      end else if (access) begin
        addr_q <= {haddr[7:2], 2'b00};
        write_pending <= hwrite;
        if (!hwrite) begin
          read_wait <= 1'b1;
          hreadyout <= 1'b0;
        end
      end else if (hready) begin
        write_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes, taken at the end of the write data phase
  // ----------------------------------------------------------------
  wire do_write = write_pending & hready & hreadyout;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_option <= `RST_CLOCK_OPTION;
      port_a_data <= `RST_PORT_A;
      port_a_dir <= `RST_PORT_A;
      port_a_pullup_ctrl <= `RST_PORT_A;
      keyboard_enable <= `RST_PORT_A;
      timer_pin_enable <= `RST_PORT_A;
      port_b_data <= `RST_PORT_B;
      port_b_dir <= `RST_PORT_B;
    end else if (do_write) begin
      case (addr_q)
        `OFS_CLOCK_OPTION: clock_option <= hwdata[1:0];
        `OFS_PORT_A_DATA: port_a_data <= hwdata[4:0];
        `OFS_PORT_A_DIR: port_a_dir <= hwdata[4:0];
        `OFS_PORT_A_PULLUP: port_a_pullup_ctrl <= hwdata[4:0];
        `OFS_KEYBOARD_ENABLE: keyboard_enable <= hwdata[4:0];
        `OFS_TIMER_PIN_ENABLE: timer_pin_enable <= hwdata[4:0];
        `OFS_PORT_B_DATA: port_b_data <= hwdata[7:0];
        `OFS_PORT_B_DIR: port_b_dir <= hwdata[7:0];
        default: clock_option <= clock_option;
      endcase
    end
  end

endmodule

// ===== test/pad_board_model.sv
// board-side pad model: external drivers, pullups and floating lines
module pad_board_model (
  // clock
  input wire logic hclk,
  // device pads
  input wire logic [4:0] port_a_pin_out,
  input wire logic [4:0] port_a_pin_oe,
  input wire logic [4:0] port_a_pin_pullup,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe,
  input wire logic external_interrupt_pullup,
  output logic [4:0] port_a_pin_in,
  output logic [7:0] port_b_pin_in,
  output logic external_interrupt_pin,
  // board drivers
  input wire logic [4:0] a_drive_en,
  input wire logic [4:0] a_drive_val,
  input wire logic ext_drive_low,
  input wire logic serial_rx_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // floating lines toggle every cycle so a missing pullup never reads as a lucky level
  logic [7:0] noise = 8'h5A;
  always @(posedge hclk) noise <= ~noise;
  assign port_a_pin_in = (port_a_pin_oe & port_a_pin_out)
    | (~port_a_pin_oe & a_drive_en & a_drive_val)
    | (~port_a_pin_oe & ~a_drive_en & (port_a_pin_pullup | noise[4:0]));
  // a board driver can hold the serial receive line low
  assign port_b_pin_in = ((port_b_pin_oe & port_b_pin_out) | (~port_b_pin_oe & noise))
    & ~{2'b00, serial_rx_low, 5'h00};
  assign external_interrupt_pin = ext_drive_low ? 1'b0
    : (external_interrupt_pullup ? 1'b1 : noise[0]);
endmodule

// ===== test/port_pin_function_select_checker.sv
// concurrent checks on the pin function select ports
module port_pin_function_select_checker (
  // clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pads
  input wire logic [4:0] port_a_pin_oe,
  input wire logic [4:0] port_a_pin_pullup,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe,
  input wire logic oscillator_input_pin_enable,
  input wire logic oscillator_output_pin_enable,
  input wire logic external_interrupt_pin,
  input wire logic external_interrupt_pullup,
  input wire logic external_interrupt_level,
  // peripherals
  input wire logic [4:0] timer_capture_input,
  input wire logic serial_enable,
  input wire logic serial_txd,
  input wire logic [3:0] adc_pin_connect
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ext_pullup_on_a: assert property (external_interrupt_pullup)
    else $error("interrupt pin pullup off");
  ext_level_low_a: assert property (!external_interrupt_pin [*4] |=> !external_interrupt_level)
    else $error("interrupt level missed low pin");
  osc_pair_a: assert property (oscillator_output_pin_enable |-> oscillator_input_pin_enable)
    else $error("oscillator output without input");
  pb6_release_a: assert property (oscillator_input_pin_enable |-> !port_b_pin_oe[6])
    else $error("bit 6 driven while oscillator owns it");
  pb7_release_a: assert property (oscillator_output_pin_enable |-> !port_b_pin_oe[7])
    else $error("bit 7 driven while oscillator owns it");
  timer_pullup_off_a: assert property ((~timer_capture_input & port_a_pin_pullup) == 5'h00)
    else $error("pullup on a timer pin");
  output_no_pullup_a: assert property ((port_a_pin_pullup & port_a_pin_oe) == 5'h00)
    else $error("pullup on a driven pin");
  serial_tx_drive_a: assert property (serial_enable |=> port_b_pin_oe[4]
    && port_b_pin_out[4] == $past(serial_txd))
    else $error("serial transmit not on bit 4");
  adc_release_a: assert property ((adc_pin_connect & port_b_pin_oe[3:0]) == 4'h0)
    else $error("analog pin driven");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  okay_resp_a: assert property (!hresp)
    else $error("error response");
endmodule

bind port_pin_function_select port_pin_function_select_checker u_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .port_a_pin_oe(port_a_pin_oe),
  .port_a_pin_pullup(port_a_pin_pullup), .port_b_pin_out(port_b_pin_out),
  .port_b_pin_oe(port_b_pin_oe), .oscillator_input_pin_enable(oscillator_input_pin_enable),
  .oscillator_output_pin_enable(oscillator_output_pin_enable),
  .external_interrupt_pin(external_interrupt_pin),
  .external_interrupt_pullup(external_interrupt_pullup),
  .external_interrupt_level(external_interrupt_level),
  .timer_capture_input(timer_capture_input), .serial_enable(serial_enable),
  .serial_txd(serial_txd),
  .adc_pin_connect(adc_pin_connect));

// ===== test/test_port_pin_function_select.sv
// self-checking testbench for the pin function select block
`include "pin_mux_defs.vh"

module test_port_pin_function_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, oscillator_input_pin_enable, oscillator_output_pin_enable;
  logic [4:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe, port_a_pin_pullup;
  logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe;
  logic external_interrupt_pin, external_interrupt_pullup, external_interrupt_level;
  logic [4:0] keyboard_interrupt_input, timer_capture_input;
  logic [4:0] timer_out = 5'h00, timer_oe = 5'h00, a_drive_en = 5'h00, a_drive_val = 5'h00;
  logic serial_enable = 1'b0, serial_txd = 1'b0, serial_rxd, ext_drive_low = 1'b0;
  logic serial_rx_low = 1'b0;
  logic [3:0] adc_channel_enable = 4'h0, adc_pin_connect;
  logic [31:0] q, q2;
  int n_fail = 0, check_count = 0, cycles = 0;

  port_pin_function_select u_port_pin_function_select (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_a_pin_in(port_a_pin_in), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe(port_a_pin_oe), .port_a_pin_pullup(port_a_pin_pullup),
    .port_b_pin_in(port_b_pin_in), .port_b_pin_out(port_b_pin_out),
    .port_b_pin_oe(port_b_pin_oe), .oscillator_input_pin_enable(oscillator_input_pin_enable),
    .oscillator_output_pin_enable(oscillator_output_pin_enable),
    .external_interrupt_pin(external_interrupt_pin),
    .external_interrupt_pullup(external_interrupt_pullup),
    .external_interrupt_level(external_interrupt_level),
    .keyboard_interrupt_input(keyboard_interrupt_input), .timer_out(timer_out),
    .timer_oe(timer_oe), .timer_capture_input(timer_capture_input),
    .serial_enable(serial_enable), .serial_txd(serial_txd), .serial_rxd(serial_rxd),
    .adc_channel_enable(adc_channel_enable),
    .adc_pin_connect(adc_pin_connect));

  pad_board_model u_pad_board_model (.hclk(hclk), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe(port_a_pin_oe), .port_a_pin_pullup(port_a_pin_pullup),
    .port_b_pin_out(port_b_pin_out), .port_b_pin_oe(port_b_pin_oe),
    .external_interrupt_pullup(external_interrupt_pullup), .port_a_pin_in(port_a_pin_in),
    .port_b_pin_in(port_b_pin_in), .external_interrupt_pin(external_interrupt_pin),
    .a_drive_en(a_drive_en), .a_drive_val(a_drive_val), .ext_drive_low(ext_drive_low),
    .serial_rx_low(serial_rx_low));

  initial forever #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  // one single transfer; the bench never assumes a wait-state count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  // pin paths need two sync stages plus the output register
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_clock_option();
    logic in_exp, out_exp;
    wr(`OFS_PORT_B_DIR, 32'hFF);
    wr(`OFS_PORT_B_DATA, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      in_exp = (i == 1) || (i == 2);
      out_exp = (i == 2);
      wr(`OFS_CLOCK_OPTION, 32'(i));
      settle();
      check({28'h0, oscillator_input_pin_enable, oscillator_output_pin_enable,
        port_b_pin_oe[7:6]}, {28'h0, in_exp, out_exp, !out_exp, !in_exp});
    end
  endtask
  task automatic test_keyboard();
    wr(`OFS_PORT_A_DIR, 32'h1F);
    wr(`OFS_PORT_A_DATA, 32'h00);
    wr(`OFS_PORT_A_PULLUP, 32'h00);
    a_drive_en <= 5'h01;
    wr(`OFS_KEYBOARD_ENABLE, 32'h15);
    settle();
    check({17'h0, port_a_pin_pullup, port_a_pin_oe, keyboard_interrupt_input},
      {17'h0, 5'h15, 5'h0A, 5'h1E});
    a_drive_en <= 5'h00;
    wr(`OFS_KEYBOARD_ENABLE, 32'h00);
  endtask
  task automatic test_gpio_pullup();
    wr(`OFS_PORT_A_DIR, 32'h03);
    wr(`OFS_PORT_A_PULLUP, 32'h1F);
    settle();
    ahb(1'b0, `OFS_PIN_STATE, 32'h0);
    q2 = q;
    ahb(1'b0, `OFS_PIN_LEVEL, 32'h0);
    check({12'h0, port_a_pin_pullup, port_a_pin_oe, q2[4:0], q[4:0]},
      {12'h0, 5'h1C, 5'h03, 5'h1C, 5'h1C});
  endtask
  task automatic test_timer();
    timer_out <= 5'h0A;
    timer_oe <= 5'h1F;
    wr(`OFS_TIMER_PIN_ENABLE, 32'h1F);
    settle();
    check({12'h0, port_a_pin_pullup, port_a_pin_oe, port_a_pin_out, timer_capture_input},
      {12'h0, 5'h00, 5'h1F, 5'h0A, 5'h0A});
    timer_oe <= 5'h00;
    wr(`OFS_TIMER_PIN_ENABLE, 32'h00);
  endtask
  task automatic test_ext_irq();
    ext_drive_low <= 1'b1;
    settle();
    check({31'h0, external_interrupt_level}, 32'h0);
    ext_drive_low <= 1'b0;
    settle();
    check({30'h0, external_interrupt_pullup, external_interrupt_level}, 32'h3);
  endtask
  task automatic test_shared_b();
    wr(`OFS_CLOCK_OPTION, 32'h0);
    wr(`OFS_PORT_B_DATA, 32'h00);
    serial_enable <= 1'b1;
    serial_txd <= 1'b1;
    serial_rx_low <= 1'b1;
    adc_channel_enable <= 4'hF;
    settle();
    check({12'h0, port_b_pin_oe, port_b_pin_out, adc_pin_connect},
      {12'h0, 8'hD0, 8'h10, 4'hF});
    check({31'h0, serial_rxd}, 32'h0);
    ahb(1'b0, 8'h30, 32'h0);
    check(q, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({19'h0, keyboard_interrupt_input, port_a_pin_pullup, oscillator_input_pin_enable,
      oscillator_output_pin_enable, external_interrupt_level}, {19'h0, 13'h1F01});
    test_clock_option();
    test_keyboard();
    test_gpio_pullup();
    test_timer();
    test_ext_irq();
    test_shared_b();
    report_and_stop();
  end
endmodule
